/* src/rmpcm_pkg.sv */
//
// Function
// - System clock from input or PLL
// - Oscillator 2*ref*M, output osc/(2*D)
// - Reset: PLL off, bypass on, no halving
// - Readable current lock status bit
// - Lock gain and loss set pending flags
// - Auto fallback follows lock loss and regain
// - Each peripheral clock switchable on its own
// - Peripherals held in reset, clock off; exempt
package rmpcm_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_PLL_CFG  = 8'h04;
    localparam logic [7:0] OFF_STATUS   = 8'h08;
    localparam logic [7:0] OFF_PEND     = 8'h0c;
    localparam logic [7:0] OFF_PCLK     = 8'h10;
    localparam logic [7:0] OFF_PRST     = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_PLL_EN      = 0;
    localparam int CTRL_BYPASS      = 1;
    localparam int CTRL_HALVE       = 2;
    localparam int CTRL_AUTO        = 3;
    localparam int CFG_MULT_LSB     = 0;
    localparam int CFG_DIV_LSB      = 8;
    localparam int STAT_LOCK        = 0;
    localparam int STAT_PLL_USED    = 1;
    localparam int STAT_SWITCHING   = 2;
    localparam int PEND_GAINED      = 0;
    localparam int PEND_LOST        = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] CTRL_RESET   = 4'h2;
    localparam logic [5:0] MULT_RESET   = 6'h01;
    localparam logic [3:0] DIV_RESET    = 4'h1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam logic [2:0] SWITCH_GAP   = 3'h4;

    // ------------------------------------------------------------
    // Clock switch states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RMPCM_IDLE   = 2'b00,
        RMPCM_GATE   = 2'b01,
        RMPCM_SWITCH = 2'b11,
        RMPCM_UNGATE = 2'b10
    } rmpcm_state_e;

endpackage : rmpcm_pkg

/* src/rmpcm_top.sv */
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module rmpcm_top
    import rmpcm_pkg::*;
#(
    parameter int          NPERIPH     = 16,
    parameter logic [15:0] EXEMPT_MASK = 16'h0023
)
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               pll_lock_pin,
    output logic                    pll_enable,
    output logic                    ref_halving_mux,
    output logic [5:0]              pll_mult,
    output logic [3:0]              pll_div,
    output logic                    sys_clk_from_pll,
    output logic                    sys_clk_enable,
    output logic [NPERIPH-1:0]      periph_clk_en,
    output logic [NPERIPH-1:0]      periph_rst_n
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [3:0]          ctrl_q;
    logic [5:0]          mult_q;
    logic [3:0]          div_q;
    logic [1:0]          pend_q;
    logic [NPERIPH-1:0]  pclk_en_q;
    logic [NPERIPH-1:0]  prst_n_q;
    logic                lk1_q;
    logic                lk2_q;
    logic                lk3_q;
    logic                lock_q;
    logic                lock_prev_q;
    logic                src_pll_q;
    logic                clk_en_q;
    logic [2:0]          gap_q;
    rmpcm_state_e        state_q;
    logic                want_pll;
    logic                acc;
    logic                wr;
    logic                mapped;
    logic [31:0]         rd_d;
    logic                rdy_q;
    logic                err_q;
    logic [31:0]         prdata_q;

    // ------------------------------------------------------------
    // Bus access
    // ------------------------------------------------------------
    assign acc = psel & penable & rdy_q;
    assign wr  = acc & pwrite & ~err_q;

    always_comb
    begin
        mapped = 1'b1;
        rd_d   = 32'h0000_0000;
        unique case (paddr)
            OFF_CTRL:
            begin
                rd_d[3:0] = ctrl_q;
            end
            OFF_PLL_CFG:
            begin
                rd_d[CFG_MULT_LSB +: 6] = mult_q;
                rd_d[CFG_DIV_LSB +: 4]  = div_q;
            end
            OFF_STATUS:
            begin
                rd_d[STAT_LOCK]      = lock_q;
                rd_d[STAT_PLL_USED]  = src_pll_q;
                rd_d[STAT_SWITCHING] = (state_q != RMPCM_IDLE);
            end
            OFF_PEND:
            begin
                rd_d[1:0] = pend_q;
            end
            OFF_PCLK:
            begin
                rd_d[NPERIPH-1:0] = pclk_en_q;
            end
            OFF_PRST:
            begin
                rd_d[NPERIPH-1:0] = prst_n_q;
            end
            default:
            begin
                mapped = 1'b0;
            end
        endcase
    end

    // One wait state, answer registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdy_q    <= 1'b0;
            err_q    <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            rdy_q    <= psel & penable & ~rdy_q;
            err_q    <= psel & penable & ~rdy_q & ~mapped;
            prdata_q <= (psel & penable & ~rdy_q & ~pwrite) ? rd_d
                                                            : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= CTRL_RESET;
            mult_q <= MULT_RESET;
            div_q  <= DIV_RESET;
        end
        else if (wr && paddr == OFF_CTRL)
        begin
            ctrl_q <= pwdata[3:0];
        end
        else if (wr && paddr == OFF_PLL_CFG)
        begin
            mult_q <= pwdata[CFG_MULT_LSB +: 6];
            div_q  <= pwdata[CFG_DIV_LSB +: 4];
        end
    end

    // ------------------------------------------------------------
    // Peripheral gating
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pclk_en_q <= EXEMPT_MASK[NPERIPH-1:0];
            prst_n_q  <= EXEMPT_MASK[NPERIPH-1:0];
        end
        else
        begin
            if (wr && paddr == OFF_PCLK)
            begin
                pclk_en_q <= pwdata[NPERIPH-1:0];
            end
            if (wr && paddr == OFF_PRST)
            begin
                prst_n_q <= pwdata[NPERIPH-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Lock synchroniser and events
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lk1_q       <= 1'b0;
            lk2_q       <= 1'b0;
            lk3_q       <= 1'b0;
            lock_q      <= 1'b0;
            lock_prev_q <= 1'b0;
        end
        else
        begin
            lk1_q       <= pll_lock_pin;
            lk2_q       <= lk1_q;
            lk3_q       <= lk2_q;
            lock_q      <= (lk2_q == lk3_q) ? lk3_q : lock_q;
            lock_prev_q <= lock_q;
        end
    end

    // Write one to clear, a new event wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend_q <= 2'b00;
        end
        else
        begin
            pend_q[PEND_GAINED] <= (lock_q & ~lock_prev_q)
                | (pend_q[PEND_GAINED]
                   & ~(wr && paddr == OFF_PEND && pwdata[PEND_GAINED]));
            pend_q[PEND_LOST] <= (~lock_q & lock_prev_q)
                | (pend_q[PEND_LOST]
                   & ~(wr && paddr == OFF_PEND && pwdata[PEND_LOST]));
        end
    end

    // ------------------------------------------------------------
    // Clock source switch
    // ------------------------------------------------------------
    assign want_pll = ctrl_q[CTRL_PLL_EN] & ~ctrl_q[CTRL_BYPASS]
                    & (~ctrl_q[CTRL_AUTO] | lock_q);

    // Gate off, change source, gate on
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q   <= RMPCM_IDLE;
            src_pll_q <= 1'b0;
            clk_en_q  <= 1'b1;
            gap_q     <= 3'h0;
        end
        else
        begin
            unique case (state_q)
                RMPCM_IDLE:
                begin
                    if (want_pll != src_pll_q)
                    begin
                        clk_en_q <= 1'b0;
                        gap_q    <= SWITCH_GAP;
                        state_q  <= RMPCM_GATE;
                    end
                end
                RMPCM_GATE:
                begin
                    if (gap_q == 3'h0)
                    begin
                        src_pll_q <= want_pll;
                        gap_q     <= SWITCH_GAP;
                        state_q   <= RMPCM_SWITCH;
                    end
                    else
                    begin
                        gap_q <= gap_q - 3'h1;
                    end
                end
                RMPCM_SWITCH:
                begin
                    if (gap_q == 3'h0)
                    begin
                        clk_en_q <= 1'b1;
                        state_q  <= RMPCM_UNGATE;
                    end
                    else
                    begin
                        gap_q <= gap_q - 3'h1;
                    end
                end
                RMPCM_UNGATE:
                begin
                    state_q <= RMPCM_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata           = prdata_q;
    assign pready           = rdy_q;
    assign pslverr          = err_q;
    assign pll_enable       = ctrl_q[CTRL_PLL_EN];
    assign ref_halving_mux  = ctrl_q[CTRL_HALVE];
    assign pll_mult         = mult_q;
    assign pll_div          = div_q;
    assign sys_clk_from_pll = src_pll_q;
    assign sys_clk_enable   = clk_en_q;
    assign periph_clk_en    = pclk_en_q;
    assign periph_rst_n     = prst_n_q;

endmodule : rmpcm_top

/* test/rmpcm_chk.sv */
`timescale 1ns/1ps
module rmpcm_chk
    import rmpcm_pkg::*;
#(
    parameter int          NPERIPH     = 16,
    parameter logic [15:0] EXEMPT_MASK = 16'h0023
)
(
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic               pll_lock_pin,
    input wire logic               pll_enable,
    input wire logic               ref_halving_mux,
    input wire logic [5:0]         pll_mult,
    input wire logic [3:0]         pll_div,
    input wire logic               sys_clk_from_pll,
    input wire logic               sys_clk_enable,
    input wire logic [NPERIPH-1:0] periph_clk_en,
    input wire logic [NPERIPH-1:0] periph_rst_n
);
    // ------------------------------------------------------------
    // Port checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable && pready && pwrite;

    a_ready_one_wait: assert property ($rose(penable) |-> !pready ##1 pready)
        else $error("pready not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    a_ctrl_write: assert property (acc && paddr == OFF_CTRL |=>
        pll_enable == $past(pwdata[CTRL_PLL_EN])
        && ref_halving_mux == $past(pwdata[CTRL_HALVE]))
        else $error("control write not applied");
    a_cfg_write: assert property (acc && paddr == OFF_PLL_CFG |=>
        pll_mult == $past(pwdata[5:0]) && pll_div == $past(pwdata[11:8]))
        else $error("multiplier write not applied");
    a_gate_write: assert property (acc && paddr == OFF_PCLK |=>
        periph_clk_en == $past(pwdata[NPERIPH-1:0]))
        else $error("clock gate write not applied");
    a_regs_hold: assert property (!acc |=> $stable(pll_mult)
        && $stable(periph_clk_en) && $stable(periph_rst_n))
        else $error("register changed without write");
    a_switch_gated: assert property ($changed(sys_clk_from_pll) |->
        !sys_clk_enable ##[3:7] sys_clk_enable)
        else $error("source changed while clock enabled");
    a_pll_needed: assert property ($rose(sys_clk_from_pll) |->
        $past(pll_enable))
        else $error("pll selected while off");
    a_reset_state: assert property ($rose(presetn) |->
        periph_clk_en == EXEMPT_MASK && periph_rst_n == EXEMPT_MASK
        && !pll_enable && !sys_clk_from_pll)
        else $error("wrong state after reset");
endmodule : rmpcm_chk

bind rmpcm_top rmpcm_chk #(.NPERIPH(NPERIPH), .EXEMPT_MASK(EXEMPT_MASK))
    rmpcm_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pll_lock_pin(pll_lock_pin), .pll_enable(pll_enable),
    .ref_halving_mux(ref_halving_mux), .pll_mult(pll_mult),
    .pll_div(pll_div), .sys_clk_from_pll(sys_clk_from_pll),
    .sys_clk_enable(sys_clk_enable), .periph_clk_en(periph_clk_en),
    .periph_rst_n(periph_rst_n));

/* test/rmpcm_bench.sv */
`timescale 1ns/1ps
module rmpcm_bench;
    import rmpcm_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and checks
    // ------------------------------------------------------------
    logic        pclk, presetn, psel, penable, pwrite, pll_lock_pin, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, pll_enable, ref_halving_mux;
    logic        sys_clk_from_pll, sys_clk_enable;
    logic [5:0]  pll_mult;
    logic [3:0]  pll_div;
    logic [15:0] periph_clk_en, periph_rst_n;
    int          n_mismatch, compares;

    rmpcm_top #(.NPERIPH(16), .EXEMPT_MASK(16'h0023)) rmpcm_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pll_lock_pin(pll_lock_pin),
        .pll_enable(pll_enable), .ref_halving_mux(ref_halving_mux),
        .pll_mult(pll_mult), .pll_div(pll_div),
        .sys_clk_from_pll(sys_clk_from_pll),
        .sys_clk_enable(sys_clk_enable), .periph_clk_en(periph_clk_en),
        .periph_rst_n(periph_rst_n));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        chk(pready, 32'h1);
        rd = prdata;
        err = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    task automatic lock(input logic v);
        @(posedge pclk);
        pll_lock_pin <= v;
        repeat (8) @(posedge pclk);
    endtask : lock

    task automatic wait_src(input logic v);
        int n;
        n = 0;
        while ((sys_clk_from_pll !== v || sys_clk_enable !== 1'b1) && n < 40)
        begin
            @(negedge pclk);
            n++;
        end
        chk(sys_clk_from_pll, v);
        chk(sys_clk_enable, 32'h1);
    endtask : wait_src

    task tally_and_finish;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    initial
    begin
        repeat (5000) @(posedge pclk);
        n_mismatch++;
        tally_and_finish();
    end

    initial
    begin
        {presetn, psel, penable, pwrite, pll_lock_pin} = 5'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        n_mismatch = 0;
        compares = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk(periph_clk_en, 32'h23);
        chk(sys_clk_from_pll, 32'h0);
        rdchk(OFF_CTRL, 32'h2);
        rdchk(OFF_PLL_CFG, 32'h101);
        rdchk(OFF_PRST, 32'h23);
        $display("reset test done");
        for (int i = 0; i < 16; i++)
        begin
            apb(1'b1, OFF_PCLK, 32'h1 << i);
            chk(periph_clk_en, 32'h1 << i);
            apb(1'b1, OFF_PRST, ~(32'h1 << i));
            chk(periph_rst_n, 32'hffff ^ (32'h1 << i));
        end
        apb(1'b1, 8'h18, 32'hffffffff);
        chk(err, 32'h1);
        rdchk(8'h18, 32'h0);
        chk(err, 32'h1);
        $display("gating test done");
        apb(1'b1, OFF_CTRL, 32'h6);
        apb(1'b1, OFF_PLL_CFG, 32'h40a);
        chk({pll_div, pll_mult}, 32'h10a);
        apb(1'b1, OFF_CTRL, 32'h7);
        chk({ref_halving_mux, pll_enable}, 32'h3);
        rdchk(OFF_STATUS, 32'h0);
        lock(1'b1);
        rdchk(OFF_STATUS, 32'h1);
        rdchk(OFF_PEND, 32'h1);
        apb(1'b1, OFF_PEND, 32'h1);
        rdchk(OFF_PEND, 32'h0);
        apb(1'b1, OFF_CTRL, 32'h5);
        rdchk(OFF_STATUS, 32'h5);
        wait_src(1'b1);
        rdchk(OFF_STATUS, 32'h3);
        $display("pll test done");
        apb(1'b1, OFF_CTRL, 32'hd);
        lock(1'b0);
        wait_src(1'b0);
        rdchk(OFF_PEND, 32'h2);
        lock(1'b1);
        wait_src(1'b1);
        rdchk(OFF_PEND, 32'h3);
        $display("fallback test done");
        apb(1'b1, OFF_CTRL, 32'h2);
        wait_src(1'b0);
        apb(1'b1, OFF_PLL_CFG, 32'h811);
        chk({pll_div, pll_mult}, 32'h211);
        $display("reprogram test done");
        tally_and_finish();
    end
endmodule : rmpcm_bench
